//--- hdl/ai_current_pkg.sv
// Constants, field layouts and carrier types for the current input block.
// Assumes a single 250 MHz system clock and a same-clock coupler port.
package ai_current_pkg;

   localparam int NUM_CH = 4;                    // Channels in the module

   // Function codes
   localparam logic [7:0] FN_OFF      = 8'hFF;
   localparam logic [7:0] FN_20_WIDE  = 8'h31;   // 0-20 mA, 27648 scale
   localparam logic [7:0] FN_20_NARR  = 8'h41;   // 0-20 mA, 16384 scale
   localparam logic [7:0] FN_420_WIDE = 8'h30;   // 4-20 mA, 27648 scale
   localparam logic [7:0] FN_420_NARR = 8'h40;   // 4-20 mA, 16384 scale
   localparam logic [7:0] FN_DEFAULT  = 8'h31;

   // Scaling on input in microamps, reduced fractions of the formulas
   localparam logic signed [31:0] MUL_20_WIDE  = 32'sh0000_0360; // 864
   localparam logic signed [31:0] DIV_20       = 32'sh0000_0271; // 625
   localparam logic signed [31:0] MUL_20_NARR  = 32'sh0000_0200; // 512
   localparam logic signed [31:0] MUL_420_WIDE = 32'sh0000_00D8; // 216
   localparam logic signed [31:0] DIV_420      = 32'sh0000_007D; // 125
   localparam logic signed [31:0] MUL_420_NARR = 32'sh0000_0080; // 128
   localparam logic signed [31:0] OFFSET_4MA   = 32'sh0000_0FA0; // 4000 uA
   localparam logic signed [31:0] HI_WIDE = 32'sh0000_7EFF;      // 32511
   localparam logic signed [31:0] LO_WIDE = 32'shFFFF_ED00;      // -4864
   localparam logic signed [31:0] HI_NARR = 32'sh0000_5000;      // 20480
   localparam logic signed [31:0] LO_NARR = 32'shFFFF_F333;      // -3277

   // Record numbers and object indexes
   localparam logic [15:0] SET_DIAG_SHORT = 16'h0000;
   localparam logic [15:0] SET_DIAG_FULL  = 16'h0001;
   localparam logic [15:0] IX_DIAG_SHORT  = 16'h2F00;
   localparam logic [15:0] IX_DIAG_FULL   = 16'h2F01;
   localparam logic [15:0] SET_FN_BASE    = 16'h0080;
   localparam logic [15:0] IX_FN_BASE     = 16'h3100;
   localparam logic [4:0]  LEN_SHORT      = 5'h04;
   localparam logic [4:0]  LEN_FULL       = 5'h14;

   // Byte positions in the diagnostic record
   localparam logic [4:0] BYTE_SUMMARY  = 5'h00;
   localparam logic [4:0] BYTE_MODINFO  = 5'h01;
   localparam logic [4:0] BYTE_INTERNAL = 5'h03;
   localparam logic [4:0] BYTE_KIND     = 5'h04;
   localparam logic [4:0] BYTE_BITS     = 5'h05;
   localparam logic [4:0] BYTE_COUNT    = 5'h06;
   localparam logic [4:0] BYTE_GROUP    = 5'h07;
   localparam logic [4:0] BYTE_CH0      = 5'h08;
   localparam logic [4:0] BYTE_STAMP    = 5'h10;

   // Field positions and constant bytes
   localparam int SUM_MOD_FAIL = 0;
   localparam int SUM_EXT_ERR  = 2;
   localparam int SUM_CH_ERR   = 3;
   localparam int SUM_AUX_MISS = 4;
   localparam int SUM_PARAM    = 7;
   localparam int INT_BUF_OVF  = 3;
   localparam int INT_COMM     = 4;
   localparam int CHE_PARAM    = 0;
   localparam int CHE_UNDER    = 6;
   localparam int CHE_OVER     = 7;
   localparam logic [7:0] MODINFO_VAL  = 8'h15;  // Analog class, info bit
   localparam logic [7:0] KIND_VAL     = 8'h71;
   localparam logic [7:0] BITS_VAL     = 8'h08;
   localparam logic [7:0] COUNT_VAL    = 8'h04;

   // Microsecond tick
   localparam int CLK_MHZ     = 250;
   localparam int TICK_CYCLES = CLK_MHZ;

   // Indexes into the synchronised status pin vector
   localparam int PIN_MOD_FAIL = 0;
   localparam int PIN_EXT_ERR  = 1;
   localparam int PIN_AUX_MISS = 2;
   localparam int PIN_BUF_OVF  = 3;
   localparam int PIN_COMM     = 4;
   localparam int NUM_PINS     = 5;

   // Coupler request and answer
   typedef struct packed {
      logic        valid;     // One-cycle request strobe
      logic        write;     // 1 = write parameter byte
      logic        by_index;  // 1 = object_index, 0 = record_set_number
      logic [15:0] id;        // Record set number or object index
      logic [4:0]  byte_sel;  // Byte within the record
      logic [7:0]  wdata;
   } rec_req_t;

   typedef struct packed {
      logic       valid;      // One-cycle answer strobe
      logic       error;      // Unknown record, byte beyond length, or write outside parameters
      logic [7:0] rdata;
   } rec_rsp_t;

   // Measurements from the front end, microamps, two's complement
   typedef struct packed {
      logic                    valid;
      logic [NUM_CH-1:0][15:0] cur_ua;
   } meas_t;

endpackage

//--- hdl/ai_current_diag.sv
// Four-channel current input scaling with diagnostic record.
// Assumes measurements arrive on the system clock from the converter
// logic; status pins come from other domains and are synchronised here.
// Record reads are answered one cycle after the request.
// No interrupt is raised; errors land in the record and channel errors on the LEDs.
`timescale 1ns/100ps
`default_nettype none

module ai_current_diag
   import ai_current_pkg::*;
(
   input  wire logic                     CLK_SYS_I,
   input  wire logic                     RSTN_I,
   input  wire meas_t                    MEAS_I,
   input  wire logic [NUM_PINS-1:0]      STATUS_PINS_I,
   input  wire rec_req_t                 REQ_I,
   output var  rec_rsp_t                 RSP_O,
   output logic [NUM_CH-1:0][15:0]       AI_VALUE_O,
   output logic [NUM_CH-1:0]             AI_ACTIVE_O,
   output logic [NUM_CH-1:0]             CH_LED_O
);

   // Parameter and diagnostic state
   // Range flags are registered; parameter errors are decoded live
   logic [NUM_CH-1:0][7:0]  fn_reg;          // channel_function_code
   logic [NUM_CH-1:0][15:0] value_reg;       // Scaled results
   logic [NUM_CH-1:0]       active_reg;      // Channel produces results
   logic [NUM_CH-1:0]       under_reg;       // Below measuring range
   logic [NUM_CH-1:0]       over_reg;        // Above measuring range
   logic [NUM_CH-1:0]       param_err;       // Unsupported function code
   logic [NUM_CH-1:0]       led_reg;         // Channel error indicators
   logic [NUM_CH-1:0]       ch_err;          // Any error per channel
   logic [NUM_CH-1:0][15:0] conv_value;      // Converted, saturated
   logic [NUM_CH-1:0]       conv_under;
   logic [NUM_CH-1:0]       conv_over;
   logic [NUM_CH-1:0]       conv_off;

   // Status pin synchroniser and filter
   // Pins come from other domains and need three stages
   logic [NUM_PINS-1:0]     pin_s1_reg;      // Read only by pin_s2_reg
   logic [NUM_PINS-1:0]     pin_s2_reg;
   logic [NUM_PINS-1:0]     pin_s3_reg;
   logic [NUM_PINS-1:0]     pin_reg;         // Accepted pin levels

   // Microsecond timer and event stamp
   // Tick divider counts system clocks per microsecond
   logic [7:0]              tick_cnt_reg;
   logic [31:0]             usec_reg;        // Free-running ticker
   logic [31:0]             stamp_reg;       // diag_usec_stamp
   logic [7:0]              summary;         // diag_summary
   logic [7:0]              internal;        // diag_internal
   logic [7:0]              group_err;       // channel_group_errors
   logic [NUM_CH*8-1:0]     flags_now;       // All error flags, flat
   logic [NUM_CH*8-1:0]     flags_prev_reg;

   // Record access
   // Decoded from the live request in the cycle it is presented
   rec_rsp_t                rsp_reg;
   rec_rsp_t                rsp_next;
   logic [7:0]              rec_byte;        // Selected record byte
   logic [4:0]              rec_len;         // Length of selected record
   logic                    rec_known;       // Diagnostic record matched
   logic                    fn_hit;          // Parameter record matched
   logic [1:0]              fn_ch;           // Parameter record channel
   logic [15:0]             fn_base;

   localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

   // Per-channel conversion, purely combinational on the live input
   // Currents arrive in microamps, so each formula is a reduced
   // fraction of integers; division truncates toward zero.
   // A 16-bit current times the largest factor stays inside
   // 32 bits, so the product cannot overflow before the divide.
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_conv
         logic signed [31:0] cur;
         logic signed [31:0] raw;
         logic signed [31:0] hi;
         logic signed [31:0] lo;
         assign cur = 32'(signed'(MEAS_I.cur_ua[ch]));

         // Select formula and limits from the function code
         // Wide limits are the default; narrow codes override them
         always_comb begin
            raw = '0;
            hi  = HI_WIDE;
            lo  = LO_WIDE;
            conv_off[ch] = 1'b0;
            case (fn_reg[ch])
               FN_20_WIDE: begin
                  raw = (cur * MUL_20_WIDE) / DIV_20;
               end
               FN_20_NARR: begin
                  raw = (cur * MUL_20_NARR) / DIV_20;
                  hi  = HI_NARR;
                  lo  = LO_NARR;
               end
               FN_420_WIDE: begin
                  raw = ((cur - OFFSET_4MA) * MUL_420_WIDE) / DIV_420;
               end
               FN_420_NARR: begin
                  raw = ((cur - OFFSET_4MA) * MUL_420_NARR) / DIV_420;
                  hi  = HI_NARR;
                  lo  = LO_NARR;
               end
               default: begin
                  // Off, or an unsupported code: no result
                  // Parameter error is decoded separately below
                  conv_off[ch] = 1'b1;
               end
            endcase
         end

         // Clamp rather than wrap; flag leaving the measuring range
         // Flags compare the unclamped value, so a reading exactly
         // on a limit is still in range
         always_comb begin
            conv_over[ch]  = !conv_off[ch] && (raw > hi);
            conv_under[ch] = !conv_off[ch] && (raw < lo);
            if (conv_off[ch]) begin
               conv_value[ch] = '0;
            end else if (conv_over[ch]) begin
               conv_value[ch] = hi[15:0];
            end else if (conv_under[ch]) begin
               conv_value[ch] = lo[15:0];
            end else begin
               conv_value[ch] = raw[15:0];
            end
         end

         // Unsupported codes other than the off code are parameter errors
         assign param_err[ch] = (fn_reg[ch] != FN_OFF) &&
                                (fn_reg[ch] != FN_20_WIDE) &&
                                (fn_reg[ch] != FN_20_NARR) &&
                                (fn_reg[ch] != FN_420_WIDE) &&
                                (fn_reg[ch] != FN_420_NARR);
         assign ch_err[ch] = param_err[ch] | under_reg[ch] | over_reg[ch];
      end
   endgenerate

   // Function codes, written by the coupler through parameter records
   // Any byte is stored as written; unsupported codes are kept so
   // the parameter error stays visible until rewritten
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         for (int i = 0; i < NUM_CH; i++) begin
            fn_reg[i] <= FN_DEFAULT;
         end
      end else if (REQ_I.valid && REQ_I.write && fn_hit) begin
         fn_reg[fn_ch] <= REQ_I.wdata;
      end
   end

   // Results and range flags follow each measurement set
   // Values hold between sets unless the channel goes off; the converter sets the pace
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         value_reg  <= '0;
         active_reg <= '0;
         under_reg  <= '0;
         over_reg   <= '0;
      end else if (MEAS_I.valid) begin
         value_reg  <= conv_value;
         active_reg <= ~conv_off;
         // Flags are rewritten each set, so they drop when clear
         under_reg  <= conv_under;
         over_reg   <= conv_over;
      end else begin
         // A channel that goes off stops reporting at once, and its
         // last value is dropped so no stale result remains
         active_reg <= active_reg & ~conv_off;
         for (int i = 0; i < NUM_CH; i++) begin
            if (conv_off[i]) begin
               value_reg[i] <= '0;
            end
         end
         under_reg  <= under_reg & ~conv_off;
         over_reg   <= over_reg & ~conv_off;
      end
   end

   // Indicator lights with the recorded error; no interrupt exists
   // One cycle behind the flags so it comes from a flip-flop
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         led_reg <= '0;
      end else begin
         led_reg <= ch_err;
      end
   end

   // Three-stage pin capture; accept a level once stages two and three agree
   // The first stage may go metastable and feeds only the second;
   // a level must stand for two samples before it is taken,
   // which also filters single-cycle glitches on the pins
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pin_s1_reg <= '0;
         pin_s2_reg <= '0;
         pin_s3_reg <= '0;
         pin_reg    <= '0;
      end else begin
         pin_s1_reg <= STATUS_PINS_I;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         for (int i = 0; i < NUM_PINS; i++) begin
            if (pin_s2_reg[i] == pin_s3_reg[i]) begin
               pin_reg[i] <= pin_s3_reg[i];
            end
         end
      end
   end

   // Microsecond ticker from the system clock; wraps after 2^32-1 us
   // Divider is fixed at the clock rate in megahertz; another
   // system clock needs a new tick count in the package
   // Counting starts when reset lets go
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         tick_cnt_reg <= '0;
         usec_reg     <= '0;
      end else if (tick_cnt_reg == TICK_LAST) begin
         tick_cnt_reg <= '0;
         usec_reg     <= usec_reg + 32'h0000_0001;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 8'h01;
      end
   end

   // Derived summary bytes; all recompute live so they also clear
   // Reserved bits are zeroed before the fields are placed
   always_comb begin
      summary = '0;
      summary[SUM_MOD_FAIL] = pin_reg[PIN_MOD_FAIL];
      summary[SUM_EXT_ERR]  = pin_reg[PIN_EXT_ERR];
      summary[SUM_CH_ERR]   = |ch_err;
      summary[SUM_AUX_MISS] = pin_reg[PIN_AUX_MISS];
      summary[SUM_PARAM]    = |param_err;
      internal = '0;
      internal[INT_BUF_OVF] = pin_reg[PIN_BUF_OVF];
      internal[INT_COMM]    = pin_reg[PIN_COMM];
      group_err = '0;
      group_err[NUM_CH-1:0] = ch_err;
   end

   // Flat view of every flag, used to spot a fresh diagnostic event
   // Parameter errors enter through the summary bits only
   always_comb begin
      flags_now = '0;
      flags_now[7:0]   = summary;
      flags_now[15:8]  = internal;
      for (int i = 0; i < NUM_CH; i++) begin
         flags_now[16+i] = under_reg[i];
         flags_now[20+i] = over_reg[i];
      end
   end

   // Stamp the ticker whenever any flag newly rises
   // A flag that clears leaves the stamp alone, so the record
   // keeps the time of the last new fault
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         flags_prev_reg <= '0;
         stamp_reg      <= '0;
      end else begin
         flags_prev_reg <= flags_now;
         if (|(flags_now & ~flags_prev_reg)) begin
            stamp_reg <= usec_reg;
         end
      end
   end

   // Parameter record lookup: sets 80h.. or indexes 3100h..
   // Only byte zero of a parameter record exists
   // Channel is the offset from the base of the chosen space
   always_comb begin
      fn_base = REQ_I.by_index ? IX_FN_BASE : SET_FN_BASE;
      fn_hit  = (REQ_I.id >= fn_base) &&
                (REQ_I.id < fn_base + 16'(NUM_CH)) &&
                (REQ_I.byte_sel == '0);
      fn_ch   = 2'(REQ_I.id - fn_base);
   end

   // Diagnostic record decode; short forms hold only four bytes
   // Both access paths reach the same bytes; only the length
   // differs between the full and the short form
   always_comb begin
      rec_known = 1'b0;
      rec_len   = LEN_FULL;
      if (!REQ_I.by_index && REQ_I.id == SET_DIAG_FULL) begin
         rec_known = 1'b1;
      end else if (!REQ_I.by_index && REQ_I.id == SET_DIAG_SHORT) begin
         rec_known = 1'b1;
         rec_len   = LEN_SHORT;
      end else if (REQ_I.by_index && REQ_I.id == IX_DIAG_FULL) begin
         rec_known = 1'b1;
      end else if (REQ_I.by_index && REQ_I.id == IX_DIAG_SHORT) begin
         rec_known = 1'b1;
         rec_len   = LEN_SHORT;
      end
   end

   // Byte multiplexer; reserved and spare bytes read as zero
   // Live flags, so a read shows the present state rather
   // than a snapshot from the time of the fault
   always_comb begin
      rec_byte = '0;
      if (REQ_I.byte_sel == BYTE_SUMMARY) begin
         rec_byte = summary;
      end else if (REQ_I.byte_sel == BYTE_MODINFO) begin
         rec_byte = MODINFO_VAL;
      end else if (REQ_I.byte_sel == BYTE_INTERNAL) begin
         rec_byte = internal;
      end else if (REQ_I.byte_sel == BYTE_KIND) begin
         rec_byte = KIND_VAL;
      end else if (REQ_I.byte_sel == BYTE_BITS) begin
         rec_byte = BITS_VAL;
      end else if (REQ_I.byte_sel == BYTE_COUNT) begin
         rec_byte = COUNT_VAL;
      end else if (REQ_I.byte_sel == BYTE_GROUP) begin
         rec_byte = group_err;
      end else if (REQ_I.byte_sel >= BYTE_CH0 &&
                   REQ_I.byte_sel < BYTE_CH0 + 5'(NUM_CH)) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (REQ_I.byte_sel == BYTE_CH0 + 5'(i)) begin
               rec_byte[CHE_PARAM] = param_err[i];
               rec_byte[CHE_UNDER] = under_reg[i];
               rec_byte[CHE_OVER]  = over_reg[i];
            end
         end
      end else if (REQ_I.byte_sel >= BYTE_STAMP &&
                   REQ_I.byte_sel < LEN_FULL) begin
         // Stamp sent least significant byte first
         rec_byte = 8'(stamp_reg >> {REQ_I.byte_sel[1:0], 3'b000});
      end
   end

   // Answer one cycle after each request; writes only to parameters
   // Every request is answered so the coupler never waits;
   // refused ones return zero with the error bit
   always_comb begin
      rsp_next = '0;
      if (REQ_I.valid) begin
         rsp_next.valid = 1'b1;
         if (REQ_I.write) begin
            rsp_next.error = !fn_hit;
         end else if (fn_hit) begin
            rsp_next.rdata = fn_reg[fn_ch];
         end else if (rec_known && REQ_I.byte_sel < rec_len) begin
            rsp_next.rdata = rec_byte;
         end else begin
            rsp_next.error = 1'b1;
         end
      end
   end

   // Registered answer
   // Stands for one cycle, then returns to zero
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rsp_reg <= '0;
      end else begin
         rsp_reg <= rsp_next;
      end
   end

   assign RSP_O       = rsp_reg;
   assign AI_VALUE_O  = value_reg;
   assign AI_ACTIVE_O = active_reg;
   assign CH_LED_O    = led_reg;

endmodule

`default_nettype wire

//--- bench/ai_current_diag_properties.sv
// Port-level properties of the current input block.
// Bound to the top module; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module ai_current_diag_checker
   import ai_current_pkg::*;
(
   input wire logic                    CLK_SYS_I,
   input wire logic                    RSTN_I,
   input wire meas_t                   MEAS_I,
   input wire logic [NUM_PINS-1:0]     STATUS_PINS_I,
   input wire rec_req_t                REQ_I,
   input wire rec_rsp_t                RSP_O,
   input wire logic [NUM_CH-1:0][15:0] AI_VALUE_O,
   input wire logic [NUM_CH-1:0]       AI_ACTIVE_O,
   input wire logic [NUM_CH-1:0]       CH_LED_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   // Read of one byte of the full record
   sequence s_rd(logic [4:0] b);
      REQ_I.valid && !REQ_I.write && !REQ_I.by_index
         && REQ_I.id == SET_DIAG_FULL && REQ_I.byte_sel == b;
   endsequence
   // Clean answer carrying a fixed byte
   sequence s_ans(logic [7:0] v);
      RSP_O.valid && !RSP_O.error && RSP_O.rdata == v;
   endsequence
   // Short-form read past its four bytes
   sequence s_short;
      REQ_I.valid && !REQ_I.write && REQ_I.byte_sel >= LEN_SHORT
         && (REQ_I.by_index ? REQ_I.id == IX_DIAG_SHORT
                            : REQ_I.id == SET_DIAG_SHORT);
   endsequence
   property p_answer;
      REQ_I.valid |=> RSP_O.valid;
   endproperty
   property p_quiet;
      !REQ_I.valid |=> !RSP_O.valid;
   endproperty
   property p_short;
      s_short |=> RSP_O.error && RSP_O.rdata == 8'h00;
   endproperty
   property p_modinfo;
      s_rd(5'h01) |=> s_ans(8'h15);
   endproperty
   property p_kind;
      s_rd(5'h04) |=> s_ans(8'h71);
   endproperty
   property p_bits;
      s_rd(5'h05) |=> s_ans(8'h08);
   endproperty
   property p_count;
      s_rd(5'h06) |=> s_ans(8'h04);
   endproperty
   property p_group;
      s_rd(5'h07) |=> RSP_O.rdata[7:4] == 4'h0;
   endproperty
   // Switched-off channel shows no value
   property p_off;
      !AI_ACTIVE_O[0] |-> AI_VALUE_O[0] == 16'h0000;
   endproperty
   property p_sat;
      $signed(AI_VALUE_O[0]) <= HI_WIDE && $signed(AI_VALUE_O[0]) >= LO_WIDE;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   a_quiet: assert property (p_quiet) else $error("stray answer");
   a_short: assert property (p_short) else $error("short len");
   a_modinfo: assert property (p_modinfo) else $error("modinfo");
   a_kind: assert property (p_kind) else $error("kind byte");
   a_bits: assert property (p_bits) else $error("bits byte");
   a_count: assert property (p_count) else $error("count byte");
   a_group: assert property (p_group) else $error("group spare");
   a_off: assert property (p_off) else $error("off value");
   a_sat: assert property (p_sat) else $error("beyond limits");
endmodule
bind ai_current_diag ai_current_diag_checker ai_current_diag_checker_i (
   .CLK_SYS_I(CLK_SYS_I), .RSTN_I(RSTN_I), .MEAS_I(MEAS_I),
   .STATUS_PINS_I(STATUS_PINS_I), .REQ_I(REQ_I), .RSP_O(RSP_O),
   .AI_VALUE_O(AI_VALUE_O), .AI_ACTIVE_O(AI_ACTIVE_O), .CH_LED_O(CH_LED_O));
`default_nettype wire

//--- bench/coupler_model.sv
// Bus coupler model issuing record reads and parameter writes.
// Assumes a same-clock request port with a one-cycle answer.
`timescale 1ns/100ps
`default_nettype none
module coupler_model
   import ai_current_pkg::*;
(
   input  wire logic     clk_i,
   output var rec_req_t  req_o,
   input  wire rec_rsp_t rsp_i
);
   initial req_o = '0;
   // One transfer; released fields are inverted so stale values
   // never pass for a fresh request
   task automatic xfer(input logic wr, input logic idx,
         input logic [15:0] id, input logic [4:0] sel,
         input logic [7:0] wd, output logic [7:0] rd,
         output logic err);
      rec_req_t held;
      held = '{1'b0, ~wr, ~idx, ~id, ~sel, ~wd};
      rd = 8'h00;
      err = 1'b1;
      @(posedge clk_i);
      req_o <= '{1'b1, wr, idx, id, sel, wd};
      for (int n = 0; n < 4; n++) begin
         @(posedge clk_i);
         if (n == 0) req_o <= held;
         #1;
         if (rsp_i.valid === 1'b1) begin
            rd = rsp_i.rdata;
            err = rsp_i.error;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking bench for the current input block.
// Drives measurements and status pins; coupler model reads the record.
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import ai_current_pkg::*;
;
   localparam logic [7:0] FNS [12] = '{8'h31, 8'h31, 8'h31, 8'h41,
      8'h41, 8'h40, 8'h40, 8'h30, 8'h30, 8'hFF, 8'h55, 8'h30};
   localparam logic [15:0] CUR [12] = '{16'h4E20, 16'h61A8, 16'hEC78,
      16'h4E20, 16'hEC78, 16'h2EE0, 16'h61A8, 16'h2EE0, 16'h0000,
      16'h4E20, 16'h4E20, 16'h4E20};
   localparam logic [15:0] VAL [12] = '{16'h6C00, 16'h7EFF, 16'hED00,
      16'h4000, 16'hF333, 16'h2000, 16'h5000, 16'h3600, 16'hED00,
      16'h0000, 16'h0000, 16'h6C00};
   localparam logic [7:0] FLG [12] = '{8'h00, 8'h80, 8'h40, 8'h00,
      8'h40, 8'h00, 8'h80, 8'h00, 8'h40, 8'h00, 8'h01, 8'h00};
   localparam logic [7:0] MSK [5] = '{8'h01, 8'h04, 8'h10, 8'h08, 8'h10};
   logic                    clk_sys;    // 250 MHz
   logic                    rstn;       // Active low
   meas_t                   meas;
   logic [NUM_PINS-1:0]     pins;
   rec_req_t                req;
   rec_rsp_t                rsp;
   logic [NUM_CH-1:0][15:0] ai_value;
   logic [NUM_CH-1:0]       ai_active;
   logic [NUM_CH-1:0]       ch_led;
   logic [7:0]              rd;
   logic                    err;
   int                      failures = 0;
   int                      comparisons = 0;
   ai_current_diag ai_current_diag_i (.CLK_SYS_I(clk_sys), .RSTN_I(rstn),
      .MEAS_I(meas), .STATUS_PINS_I(pins), .REQ_I(req), .RSP_O(rsp),
      .AI_VALUE_O(ai_value), .AI_ACTIVE_O(ai_active), .CH_LED_O(ch_led));
   coupler_model coupler_model_i (.clk_i(clk_sys), .req_o(req),
      .rsp_i(rsp));
   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdb(input logic [15:0] id, input logic idx,
         input logic [4:0] sel);
      coupler_model_i.xfer(1'b0, idx, id, sel, 8'h00, rd, err);
   endtask
   function automatic logic [7:0] exp_byte(input int b);
      return b == 1 ? 8'h15 : b == 4 ? 8'h71 : b == 5 ? 8'h08
           : b == 6 ? 8'h04 : 8'h00;
   endfunction
   // Record layout after reset, short forms and parameter defaults
   task automatic t_record;
      for (int b = 0; b < 20; b++) begin
         rdb(16'h0001, 1'b0, 5'(b));
         chk({err, rd}, {1'b0, exp_byte(b)});
      end
      rdb(16'h0000, 1'b0, 5'h04);
      chk(err, 1'b1);
      rdb(16'h2F00, 1'b1, 5'h01);
      chk({err, rd}, 9'h015);
      rdb(16'h2F00, 1'b1, 5'h04);
      chk(err, 1'b1);
      rdb(16'h2F01, 1'b1, 5'h06);
      chk({err, rd}, 9'h004);
      for (int c = 0; c < 4; c++) begin
         rdb(16'h0080 + 16'(c), 1'b0, 5'h00);
         chk({err, rd}, 9'h031);
      end
      $display("test record done");
   endtask
   // Every code and both range limits on channel 0
   task automatic t_scaling;
      for (int k = 0; k < 12; k++) begin
         coupler_model_i.xfer(1'b1, 1'b1, 16'h3100, 5'h00, FNS[k], rd, err);
         chk(err, 1'b0);
         @(posedge clk_sys);
         meas <= {1'b1, 16'h2710, 16'h2710, 16'h2710, CUR[k]};
         @(posedge clk_sys);
         meas.valid <= 1'b0;
         repeat (3) @(posedge clk_sys);
         #1;
         chk(ai_value[0], VAL[k]);
         chk(ai_active[0], FNS[k] != 8'hFF && FNS[k] != 8'h55);
         chk(ch_led[0], FLG[k] != 8'h00);
         chk({ai_active[3:1], ai_value[2]}, {3'b111, 16'h3600});
         rdb(16'h0001, 1'b0, 5'h08);
         chk(rd, FLG[k]);
         rdb(16'h0001, 1'b0, 5'h07);
         chk(rd, {7'h00, FLG[k] != 8'h00});
         rdb(16'h0001, 1'b0, 5'h00);
         chk(rd, {FLG[k][0], 3'b000, FLG[k] != 8'h00, 3'b000});
      end
      $display("test scaling done");
   endtask
   // Status pins reach summary and internal bytes; stamp moves
   task automatic t_status;
      logic [31:0] stamp;
      // Let the ticker pass two microseconds so the stamp moves
      repeat (2 * TICK_CYCLES) @(posedge clk_sys);
      for (int p = 0; p < 5; p++) begin
         @(posedge clk_sys);
         pins <= 5'(1 << p);
         repeat (8) @(posedge clk_sys);
         rdb(16'h0001, 1'b0, p < 3 ? 5'h00 : 5'h03);
         chk(rd & MSK[p], MSK[p]);
      end
      @(posedge clk_sys);
      pins <= '0;
      stamp = '0;
      for (int b = 0; b < 4; b++) begin
         rdb(16'h0001, 1'b0, 5'h10 + 5'(b));
         stamp[8*b +: 8] = rd;
      end
      chk(stamp != 32'h0000_0000, 1'b1);
      chk(stamp <= 32'($time / 1000), 1'b1);
      $display("test status done");
   endtask
   task automatic complete_run;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      meas = '0;
      pins = '0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      t_record();
      t_scaling();
      t_status();
      complete_run();
   end
   // Cuts a hang short well past the expected eight hundred or so cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      complete_run();
   end
endmodule
`default_nettype wire
